// File: hw/cpst_pkg.sv
// Shared constants, opcodes and carriers for the pointer/stop/sub/test execution unit
package cpst_pkg;

  // Wishbone geometry
  localparam int ADR_W = 12;
  localparam int DAT_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DST = 8'h00;
  localparam logic [7:0] IDX_SRC = 8'h01;
  localparam logic [7:0] IDX_CMD = 8'h02;
  localparam logic [7:0] IDX_RESULT = 8'h03;
  localparam logic [7:0] IDX_FLAGS = 8'h04;
  localparam logic [7:0] IDX_STATUS = 8'h05;
  localparam logic [7:0] IDX_PTR_FIRST = 8'hd6;
  localparam logic [7:0] IDX_PTR_SECOND = 8'hd7;

  // Flag register bit positions
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;

  // Pointer field positions
  localparam int PTR_BIT3 = 3;

  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Pointer select codes in operand bits 1:0
  localparam logic [1:0] SEL_BOTH = 2'h0;
  localparam logic [1:0] SEL_SECOND = 2'h1;
  localparam logic [1:0] SEL_FIRST = 2'h2;

  // Commands written to the command register
  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_SET_POINTERS = 3'h1,
    OP_HALT = 3'h2,
    OP_SUB = 3'h3,
    OP_SWAP = 3'h4,
    OP_TCM = 3'h5,
    OP_TM = 3'h6
  } cpst_op_e;

  // Datapath answer for one command
  typedef struct packed {
    logic [7:0] result;
    logic [7:0] flags;
    logic writeDst;
  } cpst_alu_s;

endpackage

// File: hw/cpst_exec_unit.sv
// Execution unit for pointer set, halt, subtract, nibble swap and mask tests
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Operand bits 1:0 choose pointers to update
// - Single pointer: load its bits 7:3
// - Both: load 7:4, first.3=0, second.3=1
// - Pointers sit at indices d6 and d7
// - Pointer set and halt keep flags
// - Halt enters stopped state
// - Stopped state retains all registers
// - Only reset or external interrupt wakes
// - Subtract writes destination minus source
// - Subtract sets carry, zero, sign flags
// - Subtract overflow from operand and result signs
// - Subtract forces decimal flag, sets half-borrow flag
// - Swap exchanges nibbles, sets zero, sign
// - Complement test: not dst and mask
// - Complement test: sign bit7, overflow cleared
// - Plain test: dst and mask, zero
// - Plain test: sign bit7, overflow cleared
module cpst_exec_unit (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cpst_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [cpst_pkg::DAT_W-1:0] wb_dat_i,
  output logic [cpst_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // External wake interrupt pin, asynchronous
  input wire logic extWakeIrq,
  // Stopped state indicator
  output logic cpuStopped
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] dstReg; // Destination operand
  logic [7:0] srcReg; // Source operand or mask
  logic [7:0] resultReg; // Last datapath result
  logic [7:0] flagsReg; // Flag register
  logic [7:0] ptrFirst; // First working bank pointer
  logic [7:0] ptrSecond; // Second working bank pointer
  logic [2:0] lastOp; // Last command executed
  logic wakeMeta; // Synchroniser stage one
  logic wakeSync; // Synchroniser stage two
  logic [7:0] regIdx; // Word index of access
  logic busWrite; // Write taken this edge
  logic execNow; // Command executes this edge
  cpst_pkg::cpst_op_e opCode; // Decoded command
  cpst_pkg::cpst_alu_s aluOut; // Datapath answer
  logic [8:0] subSum; // Full add of complement
  logic [4:0] nibSum; // Low nibble add
  logic [7:0] maskRes; // Test result
  logic [7:0] readData; // Read mux

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Word index from byte address
  assign regIdx = wb_adr_i[9:2];
  // Write lands on the edge that sees ack high
  assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  // Command write starts work unless stopped
  assign execNow = busWrite && (regIdx == cpst_pkg::IDX_CMD) && !cpuStopped;
  // Command code from write data
  assign opCode = cpst_pkg::cpst_op_e'(wb_dat_i[2:0]);

  // Ack one cycle after request, dropped after one cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Read mux, unmapped reads as zero
  always_comb begin
    readData = 8'h00;
    unique case (regIdx)
      cpst_pkg::IDX_DST: readData = dstReg;
      cpst_pkg::IDX_SRC: readData = srcReg;
      cpst_pkg::IDX_CMD: readData = {5'h00, lastOp};
      cpst_pkg::IDX_RESULT: readData = resultReg;
      cpst_pkg::IDX_FLAGS: readData = flagsReg;
      cpst_pkg::IDX_STATUS: readData = {7'h00, cpuStopped};
      cpst_pkg::IDX_PTR_FIRST: readData = ptrFirst;
      cpst_pkg::IDX_PTR_SECOND: readData = ptrSecond;
      default: readData = 8'h00;
    endcase
  end

  // Read data registered with the ack
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wb_dat_o <= '0;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      wb_dat_o <= {24'h000000, readData};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath

  // Flag results per command
  always_comb begin
    subSum = {1'b0, dstReg} + {1'b0, ~srcReg} + 9'h001;
    nibSum = {1'b0, dstReg[3:0]} + {1'b0, ~srcReg[3:0]} + 5'h01;
    maskRes = dstReg & srcReg;
    aluOut.result = dstReg;
    aluOut.flags = flagsReg;
    aluOut.writeDst = 1'b0;
    unique case (opCode)
      // Subtract by adding the complement
      cpst_pkg::OP_SUB: begin
        aluOut.result = subSum[7:0];
        aluOut.writeDst = 1'b1;
        aluOut.flags[cpst_pkg::FLAG_C] = srcReg > dstReg;
        aluOut.flags[cpst_pkg::FLAG_Z] = subSum[7:0] == 8'h00;
        aluOut.flags[cpst_pkg::FLAG_S] = subSum[7];
        aluOut.flags[cpst_pkg::FLAG_V] = (dstReg[7] != srcReg[7])
          && (subSum[7] == srcReg[7]);
        aluOut.flags[cpst_pkg::FLAG_D] = 1'b1;
        aluOut.flags[cpst_pkg::FLAG_H] = !nibSum[4];
      end
      // Nibble exchange, carry and overflow left as they were
      cpst_pkg::OP_SWAP: begin
        aluOut.result = {dstReg[3:0], dstReg[7:4]};
        aluOut.writeDst = 1'b1;
        aluOut.flags[cpst_pkg::FLAG_Z] = dstReg == 8'h00;
        aluOut.flags[cpst_pkg::FLAG_S] = dstReg[3];
      end
      // Complement test, operands untouched
      cpst_pkg::OP_TCM: begin
        aluOut.result = ~dstReg & srcReg;
        aluOut.flags[cpst_pkg::FLAG_Z] = (~dstReg & srcReg) == 8'h00;
        aluOut.flags[cpst_pkg::FLAG_S] = ~dstReg[7] & srcReg[7];
        aluOut.flags[cpst_pkg::FLAG_V] = 1'b0;
      end
      // Plain test, operands untouched
      cpst_pkg::OP_TM: begin
        aluOut.result = maskRes;
        aluOut.flags[cpst_pkg::FLAG_Z] = maskRes == 8'h00;
        aluOut.flags[cpst_pkg::FLAG_S] = maskRes[7];
        aluOut.flags[cpst_pkg::FLAG_V] = 1'b0;
      end
      // Pointer set and halt leave flags as they are
      cpst_pkg::OP_SET_POINTERS, cpst_pkg::OP_HALT, cpst_pkg::OP_NOP: begin
        aluOut.flags = flagsReg;
      end
      // Code 7 is not a command
      default: begin
        aluOut.flags = flagsReg;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand and result registers

  // Destination: bus write or datapath write-back, frozen while stopped
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dstReg <= cpst_pkg::DATA_RST;
    end else if (execNow && aluOut.writeDst) begin
      dstReg <= aluOut.result;
    end else if (busWrite && regIdx == cpst_pkg::IDX_DST && !cpuStopped) begin
      dstReg <= wb_dat_i[7:0];
    end
  end

  // Source operand, never written by the datapath
  always_ff @(posedge core_clk) begin
    if (reset) begin
      srcReg <= cpst_pkg::DATA_RST;
    end else if (busWrite && regIdx == cpst_pkg::IDX_SRC && !cpuStopped) begin
      srcReg <= wb_dat_i[7:0];
    end
  end

  // Result and last command capture
  always_ff @(posedge core_clk) begin
    if (reset) begin
      resultReg <= cpst_pkg::DATA_RST;
      lastOp <= 3'h0;
    end else if (execNow) begin
      resultReg <= aluOut.result;
      lastOp <= wb_dat_i[2:0];
    end
  end

  // Flags: datapath wins over a direct write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flagsReg <= cpst_pkg::FLAGS_RST;
    end else if (execNow) begin
      flagsReg <= aluOut.flags;
    end else if (busWrite && regIdx == cpst_pkg::IDX_FLAGS && !cpuStopped) begin
      flagsReg <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working bank pointers

  // First pointer update by command or bus
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ptrFirst <= cpst_pkg::PTR_RST;
    end else if (execNow && opCode == cpst_pkg::OP_SET_POINTERS) begin
      if (srcReg[1:0] == cpst_pkg::SEL_FIRST) begin
        ptrFirst[7:3] <= srcReg[7:3];
      end else if (srcReg[1:0] == cpst_pkg::SEL_BOTH) begin
        ptrFirst[7:4] <= srcReg[7:4];
        ptrFirst[cpst_pkg::PTR_BIT3] <= 1'b0;
      end
    end else if (busWrite && regIdx == cpst_pkg::IDX_PTR_FIRST && !cpuStopped) begin
      ptrFirst <= wb_dat_i[7:0];
    end
  end

  // Second pointer update by command or bus
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ptrSecond <= cpst_pkg::PTR_RST;
    end else if (execNow && opCode == cpst_pkg::OP_SET_POINTERS) begin
      if (srcReg[1:0] == cpst_pkg::SEL_SECOND) begin
        ptrSecond[7:3] <= srcReg[7:3];
      end else if (srcReg[1:0] == cpst_pkg::SEL_BOTH) begin
        ptrSecond[7:4] <= srcReg[7:4];
        ptrSecond[cpst_pkg::PTR_BIT3] <= 1'b1;
      end
    end else if (busWrite && regIdx == cpst_pkg::IDX_PTR_SECOND && !cpuStopped) begin
      ptrSecond <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stopped state

  // Wake pin synchroniser
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wakeMeta <= 1'b0;
      wakeSync <= 1'b0;
    end else begin
      wakeMeta <= extWakeIrq;
      wakeSync <= wakeMeta;
    end
  end

  // Halt enters, reset or interrupt leaves
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cpuStopped <= 1'b0;
    end else if (cpuStopped && wakeSync) begin
      cpuStopped <= 1'b0;
    end else if (execNow && opCode == cpst_pkg::OP_HALT) begin
      cpuStopped <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_exec(cpst_pkg::cpst_op_e op);
    execNow && opCode == op;
  endsequence

  sequence s_quiet_stop;
    cpuStopped && !wakeSync;
  endsequence

  AST_PTR_ONE: assert property (
    s_exec(cpst_pkg::OP_SET_POINTERS) ##0 (srcReg[1:0] == cpst_pkg::SEL_FIRST)
    |=> ptrFirst[7:3] == $past(srcReg[7:3]) && $stable(ptrSecond))
    else $error("first pointer not loaded alone");

  AST_PTR_BOTH: assert property (
    s_exec(cpst_pkg::OP_SET_POINTERS) ##0 (srcReg[1:0] == cpst_pkg::SEL_BOTH)
    |=> ptrFirst[7:3] == {$past(srcReg[7:4]), 1'b0}
        && ptrSecond[7:3] == {$past(srcReg[7:4]), 1'b1})
    else $error("both pointers load wrong");

  AST_PTR_NONE: assert property (
    s_exec(cpst_pkg::OP_SET_POINTERS) ##0 (srcReg[1:0] == 2'h3)
    |=> $stable(ptrFirst) && $stable(ptrSecond))
    else $error("pointer changed on unselected code");

  AST_FLAGS_KEEP: assert property (
    (s_exec(cpst_pkg::OP_SET_POINTERS) or s_exec(cpst_pkg::OP_HALT))
    |=> $stable(flagsReg))
    else $error("flags changed by pointer set or halt");

  AST_HALT: assert property (
    s_exec(cpst_pkg::OP_HALT) |=> cpuStopped)
    else $error("halt did not stop");

  AST_RETAIN: assert property (
    s_quiet_stop |=> $stable(dstReg) && $stable(srcReg) && $stable(flagsReg)
      && $stable(ptrFirst) && $stable(ptrSecond))
    else $error("register changed while stopped");

  AST_WAKE: assert property (
    $fell(cpuStopped) |-> $past(wakeSync))
    else $error("left stop without wake");

  AST_SUB_RES: assert property (
    s_exec(cpst_pkg::OP_SUB) |=> dstReg == 8'($past(dstReg) - $past(srcReg))
      && flagsReg[cpst_pkg::FLAG_C] == ($past(srcReg) > $past(dstReg))
      && flagsReg[cpst_pkg::FLAG_Z] == (dstReg == 8'h00)
      && flagsReg[cpst_pkg::FLAG_S] == dstReg[7])
    else $error("subtract result or flags wrong");

  AST_SUB_VDH: assert property (
    s_exec(cpst_pkg::OP_SUB) |=> flagsReg[cpst_pkg::FLAG_D]
      && flagsReg[cpst_pkg::FLAG_V] == (($past(dstReg[7]) != $past(srcReg[7]))
         && dstReg[7] == $past(srcReg[7]))
      && flagsReg[cpst_pkg::FLAG_H] == ($past(srcReg[3:0]) > $past(dstReg[3:0])))
    else $error("subtract overflow, decimal or half flag wrong");

  AST_SWAP: assert property (
    s_exec(cpst_pkg::OP_SWAP) |=> dstReg == {$past(dstReg[3:0]), $past(dstReg[7:4])}
      && flagsReg[3:2] == $past(flagsReg[3:2]) && flagsReg[cpst_pkg::FLAG_S] == dstReg[7])
    else $error("swap wrong");

  AST_TCM: assert property (
    s_exec(cpst_pkg::OP_TCM) |=> $stable(dstReg) && !flagsReg[cpst_pkg::FLAG_V]
      && flagsReg[cpst_pkg::FLAG_Z] == ((~dstReg & srcReg) == 8'h00)
      && flagsReg[cpst_pkg::FLAG_C] == $past(flagsReg[cpst_pkg::FLAG_C]))
    else $error("complement test wrong");

  AST_TM: assert property (
    s_exec(cpst_pkg::OP_TM) |=> $stable(dstReg) && !flagsReg[cpst_pkg::FLAG_V]
      && flagsReg[cpst_pkg::FLAG_S] == (dstReg[7] & srcReg[7])
      && flagsReg[cpst_pkg::FLAG_Z] == ((dstReg & srcReg) == 8'h00))
    else $error("plain test wrong");

  // Second pointer alone, kept pointer bits, untouched operands and flags, swap zero flag, complement test sign
  AST_PTR_TWO: assert property (
    s_exec(cpst_pkg::OP_SET_POINTERS) ##0 (srcReg[1:0] == cpst_pkg::SEL_SECOND)
    |=> ptrSecond[7:3] == $past(srcReg[7:3]) && $stable(ptrFirst))
    else $error("second pointer not loaded alone");

  AST_PTR_LOW: assert property (
    s_exec(cpst_pkg::OP_SET_POINTERS)
    |=> ptrFirst[2:0] == $past(ptrFirst[2:0])
      && ptrSecond[2:0] == $past(ptrSecond[2:0]))
    else $error("pointer low bits changed by pointer set");

  AST_SUB_SRC: assert property (
    s_exec(cpst_pkg::OP_SUB) |=> $stable(srcReg))
    else $error("subtract changed the source");

  AST_SWAP_ZERO: assert property (
    s_exec(cpst_pkg::OP_SWAP) |=> flagsReg[cpst_pkg::FLAG_Z] == (dstReg == 8'h00))
    else $error("swap zero flag wrong");

  AST_TEST_KEEP: assert property (
    (s_exec(cpst_pkg::OP_TCM) or s_exec(cpst_pkg::OP_TM))
    |=> $stable(srcReg)
      && flagsReg[cpst_pkg::FLAG_D] == $past(flagsReg[cpst_pkg::FLAG_D])
      && flagsReg[cpst_pkg::FLAG_H] == $past(flagsReg[cpst_pkg::FLAG_H])
      && flagsReg[cpst_pkg::FLAG_C] == $past(flagsReg[cpst_pkg::FLAG_C]))
    else $error("mask test changed kept flags or mask");

  AST_TCM_SIGN: assert property (
    s_exec(cpst_pkg::OP_TCM) |=> flagsReg[cpst_pkg::FLAG_S] == (~dstReg[7] & srcReg[7]))
    else $error("complement test sign wrong");

endmodule

`default_nettype wire

// File: verification/cpst_exec_unit_test.sv
// Self-checking bench for the pointer/stop/sub/test execution unit
`timescale 1ns/1ns
`default_nettype none

module cpst_exec_unit_test;
  // Clock, reset and bus drive
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [cpst_pkg::ADR_W-1:0] wbAdr = '0;
  logic [3:0] wbSel = 4'h0;
  logic [cpst_pkg::DAT_W-1:0] wbDatI = '0;
  logic [cpst_pkg::DAT_W-1:0] wbDatO;
  logic wbAck;
  logic extWakeIrq = 1'b0;
  logic cpuStopped;
  int errCount = 0;
  int comparisons = 0;
  logic [7:0] q;
  int n;

  ////////////////////////////////////////////////////////////////////////////
  // Design under test
  cpst_exec_unit uut (
    .core_clk(core_clk), .reset(reset), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .extWakeIrq(extWakeIrq),
    .cpuStopped(cpuStopped)
  );

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic finalReport();
    $display("errors %0d comparisons %0d", errCount, comparisons);
    if (errCount == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Byte compare
  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single-bit compare
  task automatic checkBit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch at %0t: bit got %b expected %b", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task automatic wbCycle(input logic we, input logic [7:0] idx, input logic [7:0] d,
                         output logic [7:0] rd);
    int k;
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 4'hf;
    wbAdr <= {2'h0, idx, 2'h0};
    wbDatI <= {24'h0, d};
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (wbAck !== 1'b1 && k < 50);
    if (k >= 50) begin
      errCount++;
      $display("mismatch at %0t: no bus answer", $time);
      finalReport();
    end
    rd = wbDatO[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  // Register write and read helpers
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] unused;
    wbCycle(1'b1, idx, d, unused);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] v);
    wbCycle(1'b0, idx, 8'h00, v);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reference result and flags from old flags and operands
  function automatic logic [7:0] refOp(input cpst_pkg::cpst_op_e op, input logic [7:0] d,
                                       input logic [7:0] s, inout logic [7:0] f);
    logic [7:0] r;
    if (op == cpst_pkg::OP_SUB) begin
      r = d - s;
      f[cpst_pkg::FLAG_C] = s > d;
      f[cpst_pkg::FLAG_V] = (d[7] != s[7]) && (r[7] == s[7]);
      f[cpst_pkg::FLAG_D] = 1'b1;
      f[cpst_pkg::FLAG_H] = s[3:0] > d[3:0];
    end else if (op == cpst_pkg::OP_SWAP) begin
      r = {d[3:0], d[7:4]};
    end else begin
      r = ((op == cpst_pkg::OP_TCM) ? ~d : d) & s;
      f[cpst_pkg::FLAG_V] = 1'b0;
    end
    f[cpst_pkg::FLAG_Z] = (r == 8'h00);
    f[cpst_pkg::FLAG_S] = r[7];
    return r;
  endfunction

  // Load operands, run one command, check flags, destination, source and, for mask tests, result
  task automatic runOp(input cpst_pkg::cpst_op_e op, input logic [7:0] d,
                       input logic [7:0] s, input logic [7:0] f);
    logic [7:0] r;
    logic [7:0] ef;
    logic [7:0] v;
    logic isTest;
    ef = f;
    r = refOp(op, d, s, ef);
    isTest = (op == cpst_pkg::OP_TCM) || (op == cpst_pkg::OP_TM);
    wr(cpst_pkg::IDX_FLAGS, f);
    wr(cpst_pkg::IDX_DST, d);
    wr(cpst_pkg::IDX_SRC, s);
    wr(cpst_pkg::IDX_CMD, {5'h0, op});
    rd(cpst_pkg::IDX_FLAGS, v);
    checkByte(v, ef);
    rd(cpst_pkg::IDX_DST, v);
    checkByte(v, isTest ? d : r);
    rd(cpst_pkg::IDX_SRC, v);
    checkByte(v, s);
    if (isTest) begin
      rd(cpst_pkg::IDX_RESULT, v);
      checkByte(v, r);
    end
  endtask

  // Pointer set with expected pointer values; flags must hold
  task automatic runPtr(input logic [7:0] s, input logic [7:0] e1, input logic [7:0] e2);
    logic [7:0] v;
    wr(cpst_pkg::IDX_SRC, s);
    wr(cpst_pkg::IDX_CMD, {5'h0, cpst_pkg::OP_SET_POINTERS});
    rd(cpst_pkg::IDX_PTR_FIRST, v);
    checkByte(v, e1);
    rd(cpst_pkg::IDX_PTR_SECOND, v);
    checkByte(v, e2);
    rd(cpst_pkg::IDX_FLAGS, v);
    checkByte(v, 8'ha7);
  endtask

  // Enter stopped state and confirm it
  task automatic halt();
    wr(cpst_pkg::IDX_CMD, {5'h0, cpst_pkg::OP_HALT});
    @(negedge core_clk);
    checkBit(cpuStopped, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    // Reset held for four cycles
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    rd(cpst_pkg::IDX_PTR_FIRST, q);
    checkByte(q, cpst_pkg::PTR_RST);
    rd(cpst_pkg::IDX_FLAGS, q);
    checkByte(q, cpst_pkg::FLAGS_RST);
    // Unmapped word reads zero, write dropped
    wr(8'h40, 8'h5a);
    rd(8'h40, q);
    checkByte(q, 8'h00);
    // Pointer selection cases, low bits preset to show they hold
    wr(cpst_pkg::IDX_FLAGS, 8'ha7);
    wr(cpst_pkg::IDX_PTR_FIRST, 8'h07);
    wr(cpst_pkg::IDX_PTR_SECOND, 8'h02);
    runPtr(8'h40, 8'h47, 8'h4a);
    runPtr(8'h52, 8'h57, 8'h4a);
    runPtr(8'h69, 8'h57, 8'h6a);
    runPtr(8'hf3, 8'h57, 8'h6a);
    runPtr(8'hbc, 8'hb7, 8'hba);
    // Subtract: borrow, overflow, zero, half-borrow cases
    runOp(cpst_pkg::OP_SUB, 8'h12, 8'h03, 8'h03);
    runOp(cpst_pkg::OP_SUB, 8'h21, 8'h90, 8'h00);
    runOp(cpst_pkg::OP_SUB, 8'h21, 8'h65, 8'hff);
    runOp(cpst_pkg::OP_SUB, 8'h05, 8'h05, 8'hf0);
    runOp(cpst_pkg::OP_SUB, 8'h80, 8'h01, 8'h00);
    // Swap with both old flag patterns
    runOp(cpst_pkg::OP_SWAP, 8'h3e, 8'h00, 8'hdc);
    runOp(cpst_pkg::OP_SWAP, 8'h00, 8'h00, 8'h00);
    // Mask tests
    runOp(cpst_pkg::OP_TCM, 8'hc7, 8'h02, 8'h9f);
    runOp(cpst_pkg::OP_TCM, 8'h2b, 8'h34, 8'h00);
    runOp(cpst_pkg::OP_TCM, 8'h00, 8'h80, 8'h10);
    runOp(cpst_pkg::OP_TM, 8'hc7, 8'h02, 8'h9f);
    runOp(cpst_pkg::OP_TM, 8'h2b, 8'h54, 8'h10);
    runOp(cpst_pkg::OP_TM, 8'h80, 8'h80, 8'h00);
    // Code 7 is no command: flags and destination hold, code reads back
    wr(cpst_pkg::IDX_CMD, 8'h07);
    rd(cpst_pkg::IDX_CMD, q);
    checkByte(q, 8'h07);
    rd(cpst_pkg::IDX_FLAGS, q);
    checkByte(q, 8'h20);
    rd(cpst_pkg::IDX_DST, q);
    checkByte(q, 8'h80);
    // Halt: writes ignored, flags and pointers kept, bus wakes nothing
    wr(cpst_pkg::IDX_FLAGS, 8'h5c);
    halt();
    wr(cpst_pkg::IDX_DST, 8'h11);
    wr(cpst_pkg::IDX_CMD, 8'h00);
    rd(cpst_pkg::IDX_DST, q);
    checkByte(q, 8'h80);
    rd(cpst_pkg::IDX_FLAGS, q);
    checkByte(q, 8'h5c);
    rd(cpst_pkg::IDX_STATUS, q);
    checkByte(q, 8'h01);
    @(negedge core_clk);
    checkBit(cpuStopped, 1'b1);
    // External interrupt wakes within a few cycles
    @(posedge core_clk);
    extWakeIrq <= 1'b1;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (cpuStopped !== 1'b0 && n < 8);
    if (cpuStopped !== 1'b0) begin
      errCount++;
      $display("mismatch at %0t: no wake from interrupt", $time);
      finalReport();
    end
    checkBit(cpuStopped, 1'b0);
    @(posedge core_clk);
    extWakeIrq <= 1'b0;
    rd(cpst_pkg::IDX_PTR_SECOND, q);
    checkByte(q, 8'hba);
    // Reset wakes a second stop, held for four cycles
    halt();
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    checkBit(cpuStopped, 1'b0);
    finalReport();
  end
endmodule

`default_nettype wire
